// [hdl/clcd_busy_timer.sv]
`timescale 1ns/1ns
module clcd_busy_timer #(
  parameter int W = 17
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Load
  input  wire logic         load,
  input  wire logic [W-1:0] loadValue,
  // State
  output logic              busy
);
  import clcd_pkg::*;

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic         busy_reg;

  // Down count; busy is high for exactly loadValue cycles
  assign count_next = load ? loadValue :
                      (count_reg != '0) ? W'(count_reg - 1'b1) : '0;
  assign busy       = busy_reg;

  // Counter and its flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= '0;
      busy_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      busy_reg  <= (count_next != '0);
    end
  end

  property p_busy_tracks_count;
    @(posedge clk) disable iff (sys_rst) busy == (count_reg != '0);
  endproperty
  a_busy_tracks_count: assert property (p_busy_tracks_count) else $error("busy off count");

endmodule

// [hdl/clcd_cmd_decoder.sv]
`timescale 1ns/1ns
module clcd_cmd_decoder #(
  parameter int LONG_CYCLES = clcd_pkg::LONG_CYCLES
) (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  // Register port
  input  wire logic                           busAddr,
  input  wire logic [7:0]                     busWrData,
  input  wire logic                           busWr,
  input  wire logic                           busRd,
  output logic      [7:0]                     busRdData,
  // Display state
  output logic                                busy,
  output logic                                displayOn,
  output logic                                cursorOn,
  output logic                                blinkOn,
  output logic                                entryInc,
  output logic                                entryShift,
  output logic      [clcd_pkg::FUNC_W-1:0]    funcBits,
  output logic      [clcd_pkg::DDRAM_AW-1:0]  ddramAddr,
  output logic      [clcd_pkg::CGRAM_AW-1:0]  cgramAddr,
  output logic      [clcd_pkg::DDRAM_AW-1:0]  shiftOffset,
  output logic      [7:0]                     glyphAtCursor
);
  import clcd_pkg::*;

  // Clear sweep must finish inside the busy window, even if shortened
  localparam int LONG_LOAD = (LONG_CYCLES > DDRAM_DEPTH) ? LONG_CYCLES : DDRAM_DEPTH + 1;
  localparam logic [TIMER_W-1:0] LONG_V  = TIMER_W'(LONG_LOAD);
  localparam logic [TIMER_W-1:0] SHORT_V = TIMER_W'(SHORT_CYCLES);
  localparam logic [DDRAM_AW-1:0] ONE_A  = 7'h01;
  localparam logic [DDRAM_AW-1:0] LAST_A = 7'h7f;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]          ram [DDRAM_DEPTH];
  clcd_state_t         state_reg;
  clcd_state_t         state_next;
  logic [DDRAM_AW-1:0] clearIdx_reg;
  logic [7:0]          rdData_reg;
  logic                dispOn_reg, cursor_reg, blink_reg;
  logic                entryInc_reg, entryShift_reg;
  logic [FUNC_W-1:0]   func_reg;
  logic [DDRAM_AW-1:0] ddram_reg, ddram_next;
  logic [CGRAM_AW-1:0] cgram_reg;
  logic [DDRAM_AW-1:0] offset_reg, offset_next;
  logic [7:0]          glyph_reg;
  logic                timerBusy;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Writes during busy are dropped: the host is expected to wait
  wire cmdTake   = busWr && !timerBusy && busAddr == ADDR_CMD;
  wire dataTake  = busWr && !timerBusy && busAddr == ADDR_DATA;
  wire isClear   = busWrData == CMD_CLEAR;
  wire isHome    = (busWrData & HOME_MASK) == HOME_MATCH;
  wire isEntry   = (busWrData & ENTRY_MASK) == ENTRY_MATCH;
  wire isDisp    = (busWrData & DISP_MASK) == DISP_MATCH;
  wire isShift   = (busWrData & SHIFT_MASK) == SHIFT_MATCH;
  wire isFunc    = (busWrData & FUNC_MASK) == FUNC_MATCH;
  wire isCgram   = (busWrData & CGRAM_MASK) == CGRAM_MATCH;
  wire isDdram   = (busWrData & DDRAM_MASK) == DDRAM_MATCH;
  wire shiftDisp = busWrData[SHIFT_DISP_BIT];
  wire shiftRt   = busWrData[SHIFT_RIGHT_BIT];
  wire doHome    = cmdTake && (isClear || isHome);
  wire longCmd   = doHome;
  wire timerLoad = cmdTake || dataTake;
  wire [TIMER_W-1:0] loadValue = longCmd ? LONG_V : SHORT_V;
  wire [DDRAM_AW-1:0] addrInc = DDRAM_AW'(ddram_reg + ONE_A);
  wire [DDRAM_AW-1:0] addrDec = DDRAM_AW'(ddram_reg - ONE_A);
  wire [DDRAM_AW-1:0] offInc  = DDRAM_AW'(offset_reg + ONE_A);
  wire [DDRAM_AW-1:0] offDec  = DDRAM_AW'(offset_reg - ONE_A);
  wire [7:0] statusWord = {timerBusy, ddram_reg};
  wire [7:0] readWord   = (busAddr == ADDR_CMD) ? statusWord : ram[ddram_reg];

  // Next display address: home, direct load, cursor move, data step
  assign ddram_next =
      doHome                                   ? '0 :
      (cmdTake && isDdram)                     ? busWrData[DDRAM_AW-1:0] :
      (cmdTake && isShift && !shiftDisp)       ? (shiftRt ? addrInc : addrDec) :
      dataTake                                 ? (entryInc_reg ? addrInc : addrDec) :
                                                 ddram_reg;

  // Display window offset; left shift moves text left (offset up)
  assign offset_next =
      doHome                                   ? '0 :
      (cmdTake && isShift && shiftDisp)        ? (shiftRt ? offDec : offInc) :
      (dataTake && entryShift_reg)             ? (entryInc_reg ? offInc : offDec) :
                                                 offset_reg;

  // Clear sweep runs until the last address is blanked
  always_comb begin
    case (state_reg)
      ST_IDLE:  state_next = (cmdTake && isClear) ? ST_CLEAR : ST_IDLE;
      ST_CLEAR: state_next = (clearIdx_reg == LAST_A) ? ST_IDLE : ST_CLEAR;
      default:  state_next = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Busy timer
  // ----------------------------------------------------------------
  clcd_busy_timer #(
    .W         (TIMER_W)
  ) u_timer (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .load      (timerLoad),
    .loadValue (loadValue),
    .busy      (timerBusy)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Control and address state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg      <= ST_IDLE;
      clearIdx_reg   <= '0;
      dispOn_reg     <= 1'b0;
      cursor_reg     <= 1'b0;
      blink_reg      <= 1'b0;
      entryInc_reg   <= ENTRY_INC_RST;
      entryShift_reg <= 1'b0;
      func_reg       <= FUNC_DEFAULT;
      ddram_reg      <= '0;
      cgram_reg      <= '0;
      offset_reg     <= '0;
    end else begin
      state_reg    <= state_next;
      clearIdx_reg <= (state_reg == ST_CLEAR) ? DDRAM_AW'(clearIdx_reg + ONE_A) : '0;
      ddram_reg    <= ddram_next;
      offset_reg   <= offset_next;
      if (cmdTake && isEntry) begin
        entryInc_reg   <= busWrData[ENTRY_INC_BIT];
        entryShift_reg <= busWrData[ENTRY_SHIFT_BIT];
      end
      if (cmdTake && isDisp) begin
        dispOn_reg <= busWrData[DISP_ON_BIT];
        cursor_reg <= busWrData[CURSOR_BIT];
        blink_reg  <= busWrData[BLINK_BIT];
      end
      if (cmdTake && isFunc) begin
        func_reg <= busWrData[FUNC_LSB +: FUNC_W];
      end
      if (cmdTake && isCgram) begin
        cgram_reg <= busWrData[CGRAM_AW-1:0];
      end
    end
  end

  // Display memory: sweep to blank on clear, else character store
  always_ff @(posedge clk) begin
    if (state_reg == ST_CLEAR) begin
      ram[clearIdx_reg] <= CHAR_BLANK;
    end else if (dataTake) begin
      ram[ddram_reg] <= busWrData;
    end
  end

  // Read data for exactly one cycle; glyph under the cursor
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_reg <= '0;
      glyph_reg  <= CHAR_BLANK;
    end else begin
      rdData_reg <= busRd ? readWord : '0;
      glyph_reg  <= clcd_glyph(ram[ddram_reg]);
    end
  end

  assign busRdData     = rdData_reg;
  assign busy          = timerBusy;
  assign displayOn     = dispOn_reg;
  assign cursorOn      = cursor_reg;
  assign blinkOn       = blink_reg;
  assign entryInc      = entryInc_reg;
  assign entryShift    = entryShift_reg;
  assign funcBits      = func_reg;
  assign ddramAddr     = ddram_reg;
  assign cgramAddr     = cgram_reg;
  assign shiftOffset   = offset_reg;
  assign glyphAtCursor = glyph_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_busy_set;
    @(posedge clk) disable iff (sys_rst) timerLoad |=> busy [*8];
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not held after command");

  property p_status_read;
    @(posedge clk) disable iff (sys_rst)
      busRd && busAddr == ADDR_CMD |=> busRdData == {$past(busy), $past(ddramAddr)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("bad status word");

  property p_home;
    @(posedge clk) disable iff (sys_rst)
      doHome |=> ddramAddr == '0 && shiftOffset == '0 && busy;
  endproperty
  a_home: assert property (p_home) else $error("home did not reset address");

  property p_clear_blank;
    @(posedge clk) disable iff (sys_rst)
      cmdTake && isClear |=> state_reg == ST_CLEAR ##127 state_reg == ST_CLEAR ##1
      state_reg == ST_IDLE && busy;
  endproperty
  a_clear_blank: assert property (p_clear_blank) else $error("clear sweep length");

  property p_entry;
    @(posedge clk) disable iff (sys_rst) cmdTake && isEntry |=>
      entryInc == $past(busWrData[ENTRY_INC_BIT]) && entryShift == $past(busWrData[0]);
  endproperty
  a_entry: assert property (p_entry) else $error("entry mode not set");

  property p_disp;
    @(posedge clk) disable iff (sys_rst) cmdTake && isDisp |=>
      {displayOn, cursorOn, blinkOn} == $past(busWrData[DISP_ON_BIT:BLINK_BIT]);
  endproperty
  a_disp: assert property (p_disp) else $error("display control not set");

  property p_cursor_move;
    @(posedge clk) disable iff (sys_rst) cmdTake && isShift && !shiftDisp && shiftRt |=>
      ddramAddr == DDRAM_AW'($past(ddramAddr) + ONE_A) && $stable(shiftOffset);
  endproperty
  a_cursor_move: assert property (p_cursor_move) else $error("cursor right wrong");

  property p_func;
    @(posedge clk) disable iff (sys_rst)
      cmdTake && busWrData == 8'h3c |=> funcBits == FUNC_DEFAULT;
  endproperty
  a_func: assert property (p_func) else $error("function not set");

  property p_cgram;
    @(posedge clk) disable iff (sys_rst)
      cmdTake && isCgram |=> cgramAddr == $past(busWrData[CGRAM_AW-1:0]) && $stable(ddramAddr);
  endproperty
  a_cgram: assert property (p_cgram) else $error("glyph address wrong");

  property p_ddram;
    @(posedge clk) disable iff (sys_rst)
      cmdTake && isDdram |=> ddramAddr == $past(busWrData[DDRAM_AW-1:0]);
  endproperty
  a_ddram: assert property (p_ddram) else $error("display address wrong");

  property p_char_write;
    @(posedge clk) disable iff (sys_rst) dataTake && !entryInc |=>
      ddramAddr == DDRAM_AW'($past(ddramAddr) - ONE_A) && busy;
  endproperty
  a_char_write: assert property (p_char_write) else $error("data write step wrong");

  c_clear: cover property (@(posedge clk) disable iff (sys_rst) cmdTake && isClear);
  c_char:  cover property (@(posedge clk) disable iff (sys_rst) dataTake ##1 busRd);
  c_poll:  cover property (@(posedge clk) disable iff (sys_rst) busRd && busy ##1 !busy);

endmodule

// [hdl/clcd_pkg.sv]
package clcd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 20;
  localparam int LONG_DELAY_NS  = 1650000;
  localparam int SHORT_DELAY_NS = 40000;
  // Both delay times round down to whole cycles, never below one
  localparam int LONG_CYCLES    = (LONG_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  LONG_DELAY_NS / CLK_PERIOD_NS;
  localparam int SHORT_CYCLES   = (SHORT_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  SHORT_DELAY_NS / CLK_PERIOD_NS;
  localparam int TIMER_W        = 17;

  // ----------------------------------------------------------------
  // Bus map and status layout
  // ----------------------------------------------------------------
  localparam logic ADDR_CMD  = 1'b0;
  localparam logic ADDR_DATA = 1'b1;
  localparam int   BUSY_BIT  = 7;

  // ----------------------------------------------------------------
  // Command decode masks, matches and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CLEAR     = 8'h01;
  localparam logic [7:0] HOME_MASK     = 8'hfe;
  localparam logic [7:0] HOME_MATCH    = 8'h02;
  localparam logic [7:0] ENTRY_MASK    = 8'hfc;
  localparam logic [7:0] ENTRY_MATCH   = 8'h04;
  localparam logic [7:0] DISP_MASK     = 8'hf8;
  localparam logic [7:0] DISP_MATCH    = 8'h08;
  localparam logic [7:0] SHIFT_MASK    = 8'hf0;
  localparam logic [7:0] SHIFT_MATCH   = 8'h10;
  localparam logic [7:0] FUNC_MASK     = 8'he0;
  localparam logic [7:0] FUNC_MATCH    = 8'h20;
  localparam logic [7:0] CGRAM_MASK    = 8'hc0;
  localparam logic [7:0] CGRAM_MATCH   = 8'h40;
  localparam logic [7:0] DDRAM_MASK    = 8'h80;
  localparam logic [7:0] DDRAM_MATCH   = 8'h80;
  localparam int ENTRY_INC_BIT   = 1;
  localparam int ENTRY_SHIFT_BIT = 0;
  localparam int DISP_ON_BIT     = 2;
  localparam int CURSOR_BIT      = 1;
  localparam int BLINK_BIT       = 0;
  localparam int SHIFT_DISP_BIT  = 3;
  localparam int SHIFT_RIGHT_BIT = 2;
  localparam int FUNC_LSB        = 2;
  localparam int FUNC_W          = 3;
  localparam int DDRAM_AW        = 7;
  localparam int CGRAM_AW        = 6;
  localparam int DDRAM_DEPTH     = 128;

  // ----------------------------------------------------------------
  // Reset values and character set
  // ----------------------------------------------------------------
  localparam logic [FUNC_W-1:0] FUNC_DEFAULT = 3'h7;
  localparam logic              ENTRY_INC_RST = 1'b1;
  localparam logic [7:0] CHAR_BLANK = 8'h20;
  localparam logic [7:0] CHAR_LAST  = 8'h7f;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_CLEAR = 1'b1
  } clcd_state_t;

  // Printable set is plain ASCII 0x20 to 0x7f, passed through unchanged; rest blank
  function automatic logic [7:0] clcd_glyph(input logic [7:0] code);
    clcd_glyph = (code >= CHAR_BLANK && code <= CHAR_LAST) ? code : CHAR_BLANK;
  endfunction

endpackage

// [testbench/clcd_host_model.sv]
`timescale 1ns/1ns
module clcd_host_model (
  // Clock
  input  wire logic       clk,
  // Register port toward the decoder
  output logic            busAddr,
  output logic [7:0]      busWrData,
  output logic            busWr,
  output logic            busRd,
  input  wire logic [7:0] busRdData,
  input  wire logic       busy
);
  int waitLeft;

  // ----------------------------------------------------------------
  // Idle bus at time zero
  // ----------------------------------------------------------------
  initial begin
    busAddr   = 1'b0;
    busWrData = 8'h00;
    busWr     = 1'b0;
    busRd     = 1'b0;
  end

  // One-cycle write; poll=0 lets a test hit a busy device on purpose
  task automatic wr(input logic a, input logic [7:0] d, input bit poll);
    waitLeft = 200000;
    while (poll && busy !== 1'b0 && waitLeft > 0) begin
      waitLeft--;
      @(negedge clk);
    end
    @(posedge clk);
    busAddr   <= a;
    busWrData <= d;
    busWr     <= 1'b1;
    @(posedge clk);
    busWr     <= 1'b0;
    busWrData <= ~d;   // Released data never repeats the last value
    @(negedge clk);
  endtask

  // One-cycle read; data stand only in the cycle after the strobe
  task automatic rd(input logic a, output logic [7:0] d);
    @(posedge clk);
    busAddr <= a;
    busRd   <= 1'b1;
    @(posedge clk);
    busRd   <= 1'b0;
    @(negedge clk);
    d = busRdData;
  endtask
endmodule

// [testbench/clcd_testbench.sv]
`timescale 1ns/1ns
module testbench;
  import clcd_pkg::*;
  // Short clear time keeps the run small; floor of 129 lies below it
  localparam int LONG_SMALL = 200;

  logic                clk;
  logic                sys_rst;
  logic                busAddr;
  logic [7:0]          busWrData;
  logic                busWr;
  logic                busRd;
  logic [7:0]          busRdData;
  logic                busy;
  logic                displayOn;
  logic                cursorOn;
  logic                blinkOn;
  logic                entryInc;
  logic                entryShift;
  logic [FUNC_W-1:0]   funcBits;
  logic [DDRAM_AW-1:0] ddramAddr;
  logic [CGRAM_AW-1:0] cgramAddr;
  logic [DDRAM_AW-1:0] shiftOffset;
  logic [7:0]          glyphAtCursor;
  logic [7:0]          rdVal;
  logic [7:0]          code;
  logic [DDRAM_AW-1:0] mark;
  int                  nErrors;
  int                  checksDone;

  clcd_cmd_decoder #(.LONG_CYCLES(LONG_SMALL)) dut (
    .clk(clk), .sys_rst(sys_rst), .busAddr(busAddr), .busWrData(busWrData),
    .busWr(busWr), .busRd(busRd), .busRdData(busRdData), .busy(busy),
    .displayOn(displayOn), .cursorOn(cursorOn), .blinkOn(blinkOn),
    .entryInc(entryInc), .entryShift(entryShift), .funcBits(funcBits),
    .ddramAddr(ddramAddr), .cgramAddr(cgramAddr), .shiftOffset(shiftOffset),
    .glyphAtCursor(glyphAtCursor)
  );

  clcd_host_model host (
    .clk(clk), .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr),
    .busRd(busRd), .busRdData(busRdData), .busy(busy)
  );

  // ----------------------------------------------------------------
  // Clock and shared checks
  // ----------------------------------------------------------------
  always #10 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stopTest();
    $display("checks %0d, mismatches %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Counts busy cycles from the one after the write, bounded
  task automatic measure(input int exp);
    int n;
    n = 0;
    while (busy === 1'b1 && n < 100000) begin
      n++;
      @(negedge clk);
    end
    check(32'(n), 32'(exp));
  endtask

  // Watchdog: about 30 commands of 2000 cycles each fit well inside
  initial begin
    repeat (95000) @(posedge clk);
    nErrors++;
    stopTest();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    nErrors = 0;
    checksDone = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check(busy, 0);
    check(entryInc, 1);
    check(funcBits, 3'h7);
    check(glyphAtCursor, CHAR_BLANK);
    host.wr(ADDR_CMD, CMD_CLEAR, 1);
    measure(LONG_SMALL);
    check(ddramAddr, 0);
    host.wr(ADDR_CMD, 8'hff, 1);
    measure(SHORT_CYCLES);
    check(ddramAddr, 7'h7f);
    // Status read during busy, then a write that must be dropped
    host.wr(ADDR_CMD, 8'h85, 1);
    host.rd(ADDR_CMD, rdVal);
    check(rdVal, 8'h85);
    host.wr(ADDR_DATA, 8'h41, 0);
    check(ddramAddr, 7'h05);
    host.wr(ADDR_DATA, 8'h41, 1);
    check(ddramAddr, 7'h06);
    host.wr(ADDR_CMD, 8'h85, 1);
    host.rd(ADDR_DATA, rdVal);
    check(rdVal, 8'h41);
    check(glyphAtCursor, 8'h41);
    // Every entry mode code
    for (int i = 4; i < 8; i++) begin
      host.wr(ADDR_CMD, 8'(i), 1);
      check(entryInc, i[1]);
      check(entryShift, i[0]);
    end
    host.wr(ADDR_CMD, 8'h04, 1);
    host.wr(ADDR_DATA, 8'h42, 1);
    check(ddramAddr, 7'h04);
    host.wr(ADDR_CMD, 8'h07, 1);
    mark = shiftOffset;
    host.wr(ADDR_DATA, 8'h43, 1);
    check(shiftOffset, mark + 7'h01);
    // Four display control codes: off, on, on with cursor, on with cursor and blink
    for (int k = 0; k < 4; k++) begin
      code = (k == 0) ? 8'h08 : (k == 1) ? 8'h0c : (k == 2) ? 8'h0e : 8'h0f;
      host.wr(ADDR_CMD, code, 1);
      check({displayOn, cursorOn, blinkOn}, code[2:0]);
    end
    // Cursor shifts step the address, display shifts step the offset, both directions
    mark = ddramAddr;
    host.wr(ADDR_CMD, 8'h10, 1);
    check(ddramAddr, mark - 7'h01);
    host.wr(ADDR_CMD, 8'h14, 1);
    check(ddramAddr, mark);
    mark = shiftOffset;
    host.wr(ADDR_CMD, 8'h18, 1);
    check(shiftOffset, mark + 7'h01);
    host.wr(ADDR_CMD, 8'h1c, 1);
    check(shiftOffset, mark);
    host.wr(ADDR_CMD, 8'h20, 1);
    check(funcBits, 3'h0);
    host.wr(ADDR_CMD, 8'h3c, 1);
    check(funcBits, 3'h7);
    mark = ddramAddr;
    host.wr(ADDR_CMD, 8'h7f, 1);
    check(cgramAddr, 6'h3f);
    host.wr(ADDR_CMD, 8'h40, 1);
    check(cgramAddr, 6'h00);
    check(ddramAddr, mark);
    // Home keeps data, clear blanks it
    host.wr(ADDR_CMD, 8'h02, 1);
    measure(LONG_SMALL);
    check(ddramAddr, 0);
    host.wr(ADDR_CMD, 8'h85, 1);
    host.rd(ADDR_DATA, rdVal);
    check(rdVal, 8'h42);
    host.wr(ADDR_CMD, CMD_CLEAR, 1);
    host.wr(ADDR_CMD, 8'h85, 1);
    host.rd(ADDR_DATA, rdVal);
    check(rdVal, CHAR_BLANK);
    // Code outside the printable set shows as blank
    host.wr(ADDR_DATA, 8'h10, 1);
    host.wr(ADDR_CMD, 8'h85, 1);
    host.rd(ADDR_DATA, rdVal);
    check(rdVal, 8'h10);
    check(glyphAtCursor, CHAR_BLANK);
    stopTest();
  end
endmodule
